// File: design/uhps_pkg.sv
// Package for the host port operational and suspend sequencer
package uhps_pkg;
   localparam int          CLK_HZ           = 10_000_000;
   // Register byte offsets
   localparam logic [11:0] ADDR_CMD         = 12'h000;
   localparam logic [11:0] ADDR_STATE       = 12'h004;
   localparam logic [11:0] ADDR_XCVR        = 12'h008;
   localparam logic [11:0] ADDR_CTRL        = 12'h00c;
   localparam logic [11:0] ADDR_INT_STAT    = 12'h010;
   localparam logic [11:0] ADDR_INT_MASK    = 12'h014;
   // Command codes in the host state command field
   localparam logic [2:0]  CMD_NONE         = 3'h0;
   localparam logic [2:0]  CMD_OPERATIONAL  = 3'h5;
   localparam logic [2:0]  CMD_SUSPEND      = 3'h6;
   // Field positions
   localparam int          CMD_ABORT_BIT    = 7;
   localparam int          CTRL_WAKE_BIT    = 0;
   localparam int          CTRL_SPEED_LSB   = 4;
   localparam int          INT_SUSP_BIT     = 0;
   localparam int          INT_FIRST_BIT    = 1;
   // Host state monitor values
   localparam logic [2:0]  HST_IDLE         = 3'h0;
   localparam logic [2:0]  HST_OPERATIONAL  = 3'h5;
   localparam logic [2:0]  HST_SUSPEND      = 3'h6;
   // Attached speed codes
   localparam logic [1:0]  SPD_HS           = 2'h0;
   localparam logic [1:0]  SPD_FS           = 2'h1;
   localparam logic [1:0]  SPD_LS           = 2'h2;
   // Transceiver operating modes
   localparam logic [1:0]  OPM_NORMAL       = 2'h0;
   localparam logic [1:0]  OPM_NO_STUFF     = 2'h2;
   localparam logic [1:0]  OPM_SLEEP        = 2'h3;
   // Reset values
   localparam logic [1:0]  RST_TRANSCEIVER_OPERATING_MODE       = OPM_NO_STUFF;
   localparam logic [1:0]  RST_SPEED        = SPD_FS;
   // Times, in ns, and derived cycle counts
   localparam int          T_HS_MIN_NS      = 120_000;
   localparam int          T_HS_MAX_NS      = 130_000;
   localparam int          T_FL_MIN_NS      = 900_000;
   localparam int          T_FL_MAX_NS      = 1_100_000;
   localparam int          T_RSM_MIN_NS     = 5_000_000;
   localparam int          NS_PER_CLK       = 1_000_000_000 / CLK_HZ;
   localparam int          CYC_HS_MIN       = (T_HS_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int          CYC_HS_MAX       = T_HS_MAX_NS / NS_PER_CLK;
   localparam int          CYC_FL_MIN       = (T_FL_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   localparam int          CYC_FL_MAX       = T_FL_MAX_NS / NS_PER_CLK;
   localparam int          CYC_RSM_MIN      = (T_RSM_MIN_NS + NS_PER_CLK - 1) / NS_PER_CLK;
   // Chosen target points, strictly inside the windows
   localparam int          CYC_HS_SOF       = (CYC_HS_MIN + CYC_HS_MAX) / 2;
   localparam int          CYC_FL_SOF       = (CYC_FL_MIN + CYC_FL_MAX) / 2;
   localparam int          CYC_RSM_WAIT     = CYC_RSM_MIN + 1;
   localparam int          ABORT_CYCLES     = 6;
   localparam int          CNT_W            = 20;

   typedef enum logic [2:0] {
      SQ_IDLE   = 3'b000,
      SQ_OP_WT  = 3'b001,
      SQ_OP_RUN = 3'b010,
      SQ_SU_TX  = 3'b011,
      SQ_SU_SEL = 3'b100,
      SQ_SU_WT  = 3'b101,
      SQ_SU_DN  = 3'b110
   } uhps_seq_t;
endpackage : uhps_pkg

// File: design/uhps_seq.sv
// Host port sequencer for the go-operational and go-suspend commands
`timescale 1ns/1ps
`default_nettype none

module uhps_seq
   import uhps_pkg::*;
#(
   parameter int RSM_WAIT = CYC_RSM_WAIT
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_ce,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic        i_txn_busy,
   input  wire logic        i_chan_go,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic [1:0]       o_transceiver_operating_mode,
   output logic             o_transceiver_speed_choice,
   output logic             o_termination_choice,
   output logic             o_disconnect_detect_en,
   output logic             o_wakeup_detect_en,
   output logic             o_sof_pulse,
   output logic             o_keepalive_pulse,
   output logic             o_traffic_en,
   output logic             o_irq
);

   typedef struct packed {
      uhps_seq_t        seq;
      logic [CNT_W-1:0] cnt;
      logic [2:0]       host_state_monitor;
      logic [2:0]       abort_cnt;
      logic             state_command_abort;
      logic [1:0]       transceiver_operating_mode;
      logic             hs_sel;
      logic             hs_term;
      logic             disc_en;
      logic             wake_en;
      logic             sof;
      logic             keep;
      logic             traffic;
      logic             remote_wakeup_receipt_permit;
      logic [1:0]       attached_speed;
      logic [1:0]       int_stat;
      logic [1:0]       int_mask;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             irq;
   } uhps_state_t;

   uhps_state_t st_ff;
   uhps_state_t nxt_st;

   function automatic logic [CNT_W-1:0] first_mark_wait(input logic [1:0] spd);
      first_mark_wait = (spd == SPD_HS) ? CNT_W'(CYC_HS_SOF) : CNT_W'(CYC_FL_SOF);
   endfunction : first_mark_wait

   logic       acc;
   logic       wr;
   logic       rd;
   logic       mapped;
   logic [1:0] ev;

   always_comb begin
      acc    = i_psel && i_penable && !st_ff.pready;
      wr     = acc && i_pwrite;
      rd     = acc && !i_pwrite;
      mapped = (i_paddr == ADDR_CMD) || (i_paddr == ADDR_STATE) || (i_paddr == ADDR_XCVR)
               || (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_INT_STAT)
               || (i_paddr == ADDR_INT_MASK);
      ev     = 2'h0;
      nxt_st = st_ff;
      nxt_st.sof    = 1'b0;
      nxt_st.keep   = 1'b0;
      nxt_st.pready = acc;
      nxt_st.pslverr = acc && !mapped;
      if (st_ff.cnt != '0) begin
         nxt_st.cnt = st_ff.cnt - CNT_W'(1);
      end
      if (st_ff.state_command_abort) begin
         nxt_st.abort_cnt = st_ff.abort_cnt + 3'h1;
         if (st_ff.abort_cnt == 3'(ABORT_CYCLES - 1)) begin
            nxt_st.state_command_abort = 1'b0;
            nxt_st.abort_cnt = 3'h0;
         end
      end
      unique case (st_ff.seq)
         SQ_OP_WT: begin
            if (st_ff.cnt == CNT_W'(1)) begin
               nxt_st.sof  = (st_ff.attached_speed != SPD_LS);
               nxt_st.keep = (st_ff.attached_speed == SPD_LS);
               nxt_st.traffic = 1'b1;
               nxt_st.seq  = SQ_OP_RUN;
               ev[INT_FIRST_BIT] = 1'b1;
            end
         end
         SQ_SU_TX: begin
            if (!i_txn_busy) begin
               if (st_ff.attached_speed == SPD_HS) begin
                  nxt_st.hs_sel  = 1'b0;
                  nxt_st.hs_term = 1'b0;
                  nxt_st.seq     = SQ_SU_SEL;
               end else begin
                  nxt_st.transceiver_operating_mode = OPM_SLEEP;
                  nxt_st.cnt    = CNT_W'(RSM_WAIT);
                  nxt_st.seq    = SQ_SU_WT;
               end
            end
         end
         SQ_SU_SEL: begin
            nxt_st.transceiver_operating_mode = OPM_SLEEP;
            nxt_st.cnt    = CNT_W'(RSM_WAIT);
            nxt_st.seq    = SQ_SU_WT;
         end
         SQ_SU_WT: begin
            if (st_ff.cnt == CNT_W'(1)) begin
               nxt_st.disc_en = 1'b1;
               nxt_st.wake_en = st_ff.remote_wakeup_receipt_permit;
               ev[INT_SUSP_BIT] = 1'b1;
               nxt_st.seq = SQ_SU_DN;
            end
         end
         default: begin
         end
      endcase
      if (wr) begin
         unique case (i_paddr)
            ADDR_CMD: begin
               if (i_pwdata[CMD_ABORT_BIT]) begin
                  nxt_st.state_command_abort = 1'b1;
                  nxt_st.abort_cnt = 3'h0;
                  nxt_st.seq = SQ_IDLE;
                  nxt_st.cnt = '0;
               end else if (i_pwdata[2:0] == CMD_OPERATIONAL) begin
                  nxt_st.host_state_monitor = HST_OPERATIONAL;
                  nxt_st.transceiver_operating_mode  = OPM_NORMAL;
                  nxt_st.disc_en = 1'b1;
                  nxt_st.traffic = 1'b0;
                  nxt_st.cnt = first_mark_wait(st_ff.attached_speed);
                  nxt_st.seq = SQ_OP_WT;
               end else if (i_pwdata[2:0] == CMD_SUSPEND) begin
                  nxt_st.host_state_monitor = HST_SUSPEND;
                  nxt_st.disc_en = 1'b0;
                  nxt_st.wake_en = 1'b0;
                  nxt_st.traffic = 1'b0;
                  nxt_st.cnt = '0;
                  nxt_st.seq = SQ_SU_TX;
               end
            end
            ADDR_XCVR: begin
               nxt_st.hs_sel  = i_pwdata[2];
               nxt_st.hs_term = i_pwdata[3];
            end
            ADDR_CTRL: begin
               nxt_st.remote_wakeup_receipt_permit = i_pwdata[CTRL_WAKE_BIT];
               nxt_st.attached_speed = i_pwdata[CTRL_SPEED_LSB +: 2];
            end
            ADDR_INT_MASK: nxt_st.int_mask = i_pwdata[1:0];
            default: begin
            end
         endcase
      end
      nxt_st.prdata = 32'h0;
      if (rd) begin
         unique case (i_paddr)
            ADDR_CMD:   nxt_st.prdata[CMD_ABORT_BIT] = st_ff.state_command_abort;
            ADDR_STATE: nxt_st.prdata[2:0] = st_ff.host_state_monitor;
            ADDR_XCVR:  nxt_st.prdata[3:0] = {st_ff.hs_term, st_ff.hs_sel, st_ff.transceiver_operating_mode};
            ADDR_CTRL:  nxt_st.prdata[5:0] = {st_ff.attached_speed, 3'h0,
                                              st_ff.remote_wakeup_receipt_permit};
            ADDR_INT_STAT: nxt_st.prdata[1:0] = st_ff.int_stat;
            ADDR_INT_MASK: nxt_st.prdata[1:0] = st_ff.int_mask;
            default: nxt_st.prdata = 32'h0;
         endcase
      end
      // Read clears, but an event in the same cycle still lands
      if (rd && i_paddr == ADDR_INT_STAT) begin
         nxt_st.int_stat = ev;
      end else begin
         nxt_st.int_stat = st_ff.int_stat | ev;
      end
      nxt_st.irq = |(nxt_st.int_stat & nxt_st.int_mask);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_ff <= '{seq: SQ_IDLE, host_state_monitor: HST_IDLE, transceiver_operating_mode: RST_TRANSCEIVER_OPERATING_MODE,
                    attached_speed: RST_SPEED, default: '0};
      end else if (i_ce) begin
         st_ff <= nxt_st;
      end
   end

   // Traffic beyond the first marker is launched by channel settings only
   logic chan_go_unused;
   assign chan_go_unused = i_chan_go;

   assign o_prdata                     = st_ff.prdata;
   assign o_pready                     = st_ff.pready;
   assign o_pslverr                    = st_ff.pslverr;
   assign o_transceiver_operating_mode = st_ff.transceiver_operating_mode;
   assign o_transceiver_speed_choice   = st_ff.hs_sel;
   assign o_termination_choice         = st_ff.hs_term;
   assign o_disconnect_detect_en       = st_ff.disc_en;
   assign o_wakeup_detect_en           = st_ff.wake_en;
   assign o_sof_pulse                  = st_ff.sof;
   assign o_keepalive_pulse            = st_ff.keep;
   assign o_traffic_en                 = st_ff.traffic;
   assign o_irq                        = st_ff.irq;

   op_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && wr && i_paddr == ADDR_CMD && !i_pwdata[CMD_ABORT_BIT]
       && i_pwdata[2:0] == CMD_OPERATIONAL)
      |=> st_ff.host_state_monitor == HST_OPERATIONAL && o_disconnect_detect_en
          && o_transceiver_operating_mode == OPM_NORMAL)
      else $error("operational entry wrong");
   su_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && wr && i_paddr == ADDR_CMD && !i_pwdata[CMD_ABORT_BIT]
       && i_pwdata[2:0] == CMD_SUSPEND)
      |=> st_ff.host_state_monitor == HST_SUSPEND && !o_disconnect_detect_en
          && !o_wakeup_detect_en)
      else $error("suspend entry wrong");
   mark_kind_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_keepalive_pulse |-> st_ff.attached_speed == SPD_LS && !o_sof_pulse)
      else $error("wrong first marker kind");
   hs_window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && wr && i_paddr == ADDR_CMD && !i_pwdata[CMD_ABORT_BIT]
       && i_pwdata[2:0] == CMD_OPERATIONAL && st_ff.attached_speed == SPD_HS)
      |=> st_ff.cnt > CNT_W'(CYC_HS_MIN) && st_ff.cnt < CNT_W'(CYC_HS_MAX))
      else $error("hs marker window");
   fl_window_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && wr && i_paddr == ADDR_CMD && !i_pwdata[CMD_ABORT_BIT]
       && i_pwdata[2:0] == CMD_OPERATIONAL && st_ff.attached_speed != SPD_HS)
      |=> st_ff.cnt > CNT_W'(CYC_FL_MIN) && st_ff.cnt < CNT_W'(CYC_FL_MAX))
      else $error("fs ls marker window");
   mark_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_OP_WT && st_ff.cnt > CNT_W'(1))
      |=> st_ff.seq == SQ_OP_WT && st_ff.cnt == $past(st_ff.cnt) - CNT_W'(1))
      else $error("marker countdown skipped");
   mark_fire_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_OP_WT && st_ff.cnt == CNT_W'(1))
      |=> (o_sof_pulse || o_keepalive_pulse) && st_ff.seq == SQ_OP_RUN)
      else $error("first marker missing");
   sof_kind_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_sof_pulse |-> st_ff.attached_speed != SPD_LS && !o_keepalive_pulse)
      else $error("frame start on low speed");
   traffic_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_sof_pulse || o_keepalive_pulse) |-> o_traffic_en)
      else $error("traffic not enabled at marker");
   traffic_off_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      st_ff.seq == SQ_OP_WT |-> !o_traffic_en)
      else $error("traffic before first marker");
   sleep_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ($rose(o_transceiver_operating_mode == OPM_SLEEP) && st_ff.attached_speed == SPD_HS)
      |-> !o_transceiver_speed_choice && !o_termination_choice)
      else $error("sleep before full speed select");
   txn_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.seq == SQ_SU_TX && i_txn_busy) |=> o_transceiver_operating_mode != OPM_SLEEP
      || st_ff.seq != SQ_SU_WT)
      else $error("powered down during transaction");
   rearm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.seq == SQ_SU_WT && st_ff.cnt > CNT_W'(1)) |-> !o_disconnect_detect_en)
      else $error("detection rearmed early");
   done_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(o_disconnect_detect_en) && st_ff.seq == SQ_SU_DN
      |-> st_ff.int_stat[INT_SUSP_BIT]
          && o_wakeup_detect_en == st_ff.remote_wakeup_receipt_permit)
      else $error("done flag missing");
   abort_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.state_command_abort && st_ff.abort_cnt == 3'h0 && i_ce) ##1 i_ce [*5]
      |=> !st_ff.state_command_abort)
      else $error("abort bit stuck");
   irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_irq == |(st_ff.int_stat & st_ff.int_mask))
      else $error("interrupt mismatch");
   hs_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_SU_TX && !i_txn_busy
       && st_ff.attached_speed == SPD_HS)
      |=> !o_transceiver_speed_choice && !o_termination_choice && st_ff.seq == SQ_SU_SEL)
      else $error("hs selections not dropped");
   hs_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_SU_SEL)
      |=> o_transceiver_operating_mode == OPM_SLEEP && st_ff.seq == SQ_SU_WT)
      else $error("hs power-down missing");
   fl_sleep_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_SU_TX && !i_txn_busy
       && st_ff.attached_speed != SPD_HS)
      |=> o_transceiver_operating_mode == OPM_SLEEP
          && o_transceiver_speed_choice == $past(o_transceiver_speed_choice)
          && o_termination_choice == $past(o_termination_choice))
      else $error("fs ls power-down wrong");
   detect_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (st_ff.seq == SQ_SU_TX || st_ff.seq == SQ_SU_SEL || st_ff.seq == SQ_SU_WT)
      |-> !o_disconnect_detect_en && !o_wakeup_detect_en)
      else $error("detection on during suspend entry");
   done_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !wr && st_ff.seq == SQ_SU_WT && st_ff.cnt == CNT_W'(1))
      |=> o_disconnect_detect_en && st_ff.int_stat[INT_SUSP_BIT] && st_ff.seq == SQ_SU_DN)
      else $error("suspend completion missing");
   stat_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && !(rd && i_paddr == ADDR_INT_STAT))
      |=> (st_ff.int_stat & $past(st_ff.int_stat)) == $past(st_ff.int_stat))
      else $error("status flag lost");
   abort_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && wr && i_paddr == ADDR_CMD && i_pwdata[CMD_ABORT_BIT])
      |=> st_ff.state_command_abort && st_ff.seq == SQ_IDLE)
      else $error("abort not taken");
   pready_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_ce && o_pready) |=> !o_pready)
      else $error("ready held too long");
   slverr_ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      o_pslverr |-> o_pready)
      else $error("error without ready");
   ce_freeze_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_ce |=> st_ff == $past(st_ff))
      else $error("state moved while disabled");

endmodule : uhps_seq

`default_nettype wire

// File: tb/tb_usb_host_port_operational_suspend_seq.sv
// Testbench for the host port sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_usb_host_port_operational_suspend_seq;
   import uhps_pkg::*;
   localparam int RSM = 20;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hold_go = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, sp_sel, term_sel, disc_en, wake_en, sof, kal, traf, irq;
   logic        busy, chan_go, rev, err;
   logic [1:0]  transceiver_operating_mode, spd;
   int          fail_count = 0, samples_checked = 0, cyc = 0, n;
   always #50 clk = ~clk;
   uhps_seq #(.RSM_WAIT(RSM)) uhps_seq_inst (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .i_txn_busy(busy), .i_chan_go(chan_go), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_transceiver_operating_mode(transceiver_operating_mode),
      .o_transceiver_speed_choice(sp_sel), .o_termination_choice(term_sel),
      .o_disconnect_detect_en(disc_en), .o_wakeup_detect_en(wake_en), .o_sof_pulse(sof),
      .o_keepalive_pulse(kal), .o_traffic_en(traf), .o_irq(irq));
   uhps_usb_peer #(.HOLD_LEN(12), .REV_CYC(12)) uhps_usb_peer_inst (.i_clk(clk),
      .i_rst_n(rst_n), .i_hold_go(hold_go), .i_transceiver_operating_mode(transceiver_operating_mode), .i_traffic_en(traf),
      .o_txn_busy(busy), .o_chan_go(chan_go), .o_fs_revert(rev));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // One APB transfer; the request is held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   // Whole run needs some 21500 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check("transceiver_operating_mode_rst", {30'h0, transceiver_operating_mode}, {30'h0, RST_TRANSCEIVER_OPERATING_MODE});
      apb(1'b0, ADDR_XCVR, 32'h0);
      check("xcvr_rst", rd, {30'h0, RST_TRANSCEIVER_OPERATING_MODE});
      apb(1'b0, ADDR_CTRL, 32'h0);
      check("ctrl_rst", rd, {26'h0, RST_SPEED, 4'h0});
      apb(1'b0, 12'h0f0, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      apb(1'b1, ADDR_INT_MASK, 32'h3);
      $display("test reset done");
      for (int s = 0; s < 3; s++) begin
         spd = (s == 0) ? SPD_HS : (s == 1) ? SPD_FS : SPD_LS;
         apb(1'b1, ADDR_CTRL, {26'h0, spd, 3'h0, 1'(s == 0)});
         apb(1'b1, ADDR_XCVR, 32'hc);
         apb(1'b1, ADDR_CMD, {29'h0, CMD_OPERATIONAL});
         check("transceiver_operating_mode_op", {30'h0, transceiver_operating_mode}, {30'h0, OPM_NORMAL});
         check("disc_op", {31'h0, disc_en}, 32'h1);
         n = 0;
         while (sof !== 1'b1 && kal !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
         end
         check("sof_kind", {31'h0, sof}, {31'h0, 1'(spd != SPD_LS)});
         check("kal_kind", {31'h0, kal}, {31'h0, 1'(spd == SPD_LS)});
         if (s == 0) begin
            check("hs_time", {31'h0, 1'(n + 1 > CYC_HS_MIN && n + 1 < CYC_HS_MAX)}, 1);
         end else begin
            check("fl_time", {31'h0, 1'(n + 1 > CYC_FL_MIN && n + 1 < CYC_FL_MAX)}, 1);
         end
         apb(1'b0, ADDR_STATE, 32'h0);
         check("state_op", rd, {29'h0, HST_OPERATIONAL});
         check("traffic", {31'h0, traf}, 32'h1);
         check("irq_first", {31'h0, irq}, 32'h1);
         apb(1'b0, ADDR_INT_STAT, 32'h0);
         @(posedge clk);
         check("stat_first", rd, 32'h2);
         check("irq_clear", {31'h0, irq}, 32'h0);
         // Peer keeps a transaction open across the suspend request
         hold_go <= 1'b1;
         apb(1'b1, ADDR_CMD, {29'h0, CMD_SUSPEND});
         hold_go <= 1'b0;
         check("det_off", {30'h0, disc_en, wake_en}, 32'h0);
         check("transceiver_operating_mode_busy", {30'h0, transceiver_operating_mode}, {30'h0, OPM_NORMAL});
         apb(1'b0, ADDR_STATE, 32'h0);
         check("state_su", rd, {29'h0, HST_SUSPEND});
         n = 0;
         while (transceiver_operating_mode !== OPM_SLEEP && n < 100) begin
            @(posedge clk);
            n++;
         end
         check("sleep_mode", {30'h0, transceiver_operating_mode}, {30'h0, OPM_SLEEP});
         check("peer_fs_early", {31'h0, rev}, 32'h0);
         check("busy_at_sleep", {31'h0, busy}, 32'h0);
         check("sel_at_sleep", {30'h0, sp_sel, term_sel}, (s == 0) ? 32'h0 : 32'h3);
         n = 0;
         while (disc_en !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
         end
         check("rearm_time", {31'h0, 1'(n >= RSM && n <= RSM + 1)}, 1);
         check("peer_fs_late", {31'h0, rev}, 32'h1);
         check("wake_en", {31'h0, wake_en}, {31'h0, 1'(s == 0)});
         @(posedge clk);
         check("irq_done", {31'h0, irq}, 32'h1);
         apb(1'b0, ADDR_INT_STAT, 32'h0);
         check("stat_done", rd, 32'h1);
         $display("test speed %0d done", s);
      end
      apb(1'b1, ADDR_CMD, 32'h80);
      // A low clock enable must also hold the abort countdown
      ce <= 1'b0;
      repeat (10) @(posedge clk);
      ce <= 1'b1;
      apb(1'b0, ADDR_CMD, 32'h0);
      check("abort_set", {31'h0, rd[CMD_ABORT_BIT]}, 32'h1);
      repeat (8) @(posedge clk);
      apb(1'b0, ADDR_CMD, 32'h0);
      check("abort_clear", {31'h0, rd[CMD_ABORT_BIT]}, 32'h0);
      $display("test abort done");
      report_and_stop();
   end
endmodule : tb_usb_host_port_operational_suspend_seq
`default_nettype wire

// File: tb/uhps_usb_peer.sv
// Model of the peripheral attached to the downstream port
`timescale 1ns/1ps
`default_nettype none
module uhps_usb_peer
   import uhps_pkg::*;
#(
   parameter int HOLD_LEN = 12,
   parameter int REV_CYC  = 30600
) (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_hold_go,
   input  wire logic [1:0] i_transceiver_operating_mode,
   input  wire logic       i_traffic_en,
   output logic            o_txn_busy,
   output logic            o_chan_go,
   output logic            o_fs_revert
);
   logic [7:0] hold_cnt_ff;
   int         sleep_cnt_ff;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hold_cnt_ff  <= 8'h00;
         sleep_cnt_ff <= 0;
         o_fs_revert  <= 1'b0;
      end else begin
         if (i_hold_go) begin
            hold_cnt_ff <= 8'(HOLD_LEN);
         end else if (hold_cnt_ff != 8'h00) begin
            hold_cnt_ff <= hold_cnt_ff - 8'h01;
         end
         // Falls back to full speed some 3 ms into a powered-down bus
         if (i_transceiver_operating_mode == OPM_SLEEP) begin
            if (sleep_cnt_ff < REV_CYC) begin
               sleep_cnt_ff <= sleep_cnt_ff + 1;
            end else begin
               o_fs_revert <= 1'b1;
            end
         end else begin
            sleep_cnt_ff <= 0;
            o_fs_revert  <= 1'b0;
         end
      end
   end
   // A transaction in flight blocks new channel requests
   assign o_txn_busy = (hold_cnt_ff != 8'h00);
   assign o_chan_go  = i_traffic_en & ~o_txn_busy;
endmodule : uhps_usb_peer
`default_nettype wire
